//--- verilog/enc_loss_pkg.sv
/*
 Constants, register map and carrier types for the encoder loss monitor.
 Assumes a single 200 MHz clock and an AHB-Lite register bus.
*/
package enc_loss_pkg;
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned MS_UNIT_HZ   = 1000;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_UNIT_HZ;
   localparam int unsigned HF_DELAY_MS  = 40;
   localparam int unsigned SAMPLE_MS    = 10;
   // Frequency in 0.01 Hz per counted A edge in one sampling period
   localparam logic [31:0] FREQ_SCALE   = 32'(100_000 / SAMPLE_MS);
   localparam logic [15:0] THRESH_RST   = 16'h03E8;
   localparam logic [15:0] DELAY_RST    = 16'h000A;
   localparam logic        SEL_RST      = 1'b0;
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  THRESH_OFS   = 8'h04;
   localparam logic [7:0]  DELAY_OFS    = 8'h08;
   localparam logic [7:0]  FREQ_OFS     = 8'h0C;
   localparam logic [7:0]  LIVE_OFS     = 8'h10;
   localparam logic [7:0]  INT_STAT_OFS = 8'h14;
   localparam logic [7:0]  INT_MASK_OFS = 8'h18;
   localparam int unsigned INT_HF       = 0;
   localparam int unsigned INT_LF       = 1;
   localparam int unsigned INT_REACT    = 2;
   localparam int unsigned INT_W        = 3;

   typedef struct packed {
      logic        reaction_sel;
      logic [15:0] threshold;
      logic [15:0] delay_ms;
   } cfg_t;

   typedef struct packed {
      logic encoder_loss_fault;
      logic coast_trip_stop;
      logic encoder_loss_warning;
      logic sensorless_vector_fallback;
   } reaction_t;

   typedef enum logic [1:0] {
      MON_IDLE  = 2'b00,
      MON_WAIT  = 2'b01,
      MON_REACT = 2'b10
   } mon_state_t;
endpackage

//--- verilog/speed_encoder_loss_monitor.sv
/*
 Speed encoder input stage with encoder signal loss supervision and an
 AHB-Lite register slave. Assumes encoder pins are asynchronous, and that
 torque limit and setpoint flags come from logic on ref_clk.
*/
// Implementation choices: register access over AHB-Lite and the register addresses.
// How it works
// [R01] Direction sensed only with both tracks
// [R02] Three non-inverting inputs A, B, Z
// [R03] Select 0 trips by coasting, 1 warns, sensorless
// [R04] One threshold for both loss checks
// [R05] High loss: frequency and step exceed threshold
// [R06] High loss needs 40 ms persistence
// [R07] Low loss when either condition set holds
// [R08] Set one: slow, zero speed, limit, setpoint
// [R09] Set two: slow, latest slow, track B fault
// [R10] Reaction waits the configured loss delay
// [R11] Zero threshold disables all loss monitoring
// [R12] Zero delay disables only low loss
// [R13] Frequency per sample period, previous kept
`timescale 1ns/100ps
module speed_encoder_loss_monitor
   import enc_loss_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        enc_z,
   input  wire logic        torque_at_limit,
   input  wire logic        setpoint_positive,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             encoder_loss_fault,
   output logic             coast_trip_stop,
   output logic             encoder_loss_warning,
   output logic             sensorless_vector_fallback,
   output logic             irq
);
   logic [2:0]  a_s_reg, b_s_reg, z_s_reg;
   logic        a_lvl_reg, b_lvl_reg, z_seen_reg, dir_reg;
   logic        a_lvl_next, b_lvl_next, z_seen_next, dir_next, a_rise, b_rise;
   logic [31:0] ms_cnt_reg, ms_cnt_next;
   logic [15:0] smp_ms_reg, smp_ms_next, a_cnt_reg, a_cnt_next, b_cnt_reg, b_cnt_next;
   logic        ms_tick, smp_tick;
   logic [31:0] cur_f_reg, cur_f_next, prev_f_reg, prev_f_next, f_act, f_diff, thr32;
   logic        b_bad_reg, b_bad_next, zero_reg, zero_next, b_ok_reg, b_ok_next;
   logic [15:0] hf_ms_reg, hf_ms_next, zs_ms_reg, zs_ms_next, wait_ms_reg, wait_ms_next;
   logic        hf_cond, hf_loss, lf_case1, lf_case2, lf_loss, loss;
   logic        hf_loss_d_reg, lf_loss_d_reg;
   mon_state_t  state_reg, state_next;
   reaction_t   react_reg, react_next;
   cfg_t        cfg_reg, cfg_next;
   logic [INT_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
   logic        wr_pend_reg, wr_pend_next;
   logic [7:0]  wr_ofs_reg, wr_ofs_next;
   logic [31:0] hrdata_next;
   logic        ack_wr, acc;

   // Encoder pins: three stages, a change counts once stages two and three agree
   always_comb begin
      a_lvl_next  = (a_s_reg[1] == a_s_reg[2]) ? a_s_reg[2] : a_lvl_reg; // R02
      b_lvl_next  = (b_s_reg[1] == b_s_reg[2]) ? b_s_reg[2] : b_lvl_reg;
      a_rise      = a_lvl_next & ~a_lvl_reg;
      b_rise      = b_lvl_next & ~b_lvl_reg;
      // A new index pulse wins over an acknowledge in the same cycle
      z_seen_next = (z_seen_reg & ~ack_wr) | ((z_s_reg[1] == z_s_reg[2]) & z_s_reg[2]);
      // B level at an A rise gives the sense of rotation
      dir_next    = (a_rise & b_ok_reg) ? ~b_lvl_reg : dir_reg; // R01
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_s_reg    <= 3'h0;
         b_s_reg    <= 3'h0;
         z_s_reg    <= 3'h0;
         a_lvl_reg  <= 1'b0;
         b_lvl_reg  <= 1'b0;
         z_seen_reg <= 1'b0;
         dir_reg    <= 1'b0;
      end else begin
         a_s_reg    <= {a_s_reg[1:0], enc_a};
         b_s_reg    <= {b_s_reg[1:0], enc_b};
         z_s_reg    <= {z_s_reg[1:0], enc_z};
         a_lvl_reg  <= a_lvl_next;
         b_lvl_reg  <= b_lvl_next;
         z_seen_reg <= z_seen_next;
         dir_reg    <= dir_next;
      end
   end

   // Millisecond enable, sampling period and edge counting
   always_comb begin
      ms_tick     = (ms_cnt_reg == 32'(CYC_MS - 1));
      ms_cnt_next = ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
      smp_tick    = ms_tick && (smp_ms_reg == 16'(SAMPLE_MS - 1));
      smp_ms_next = smp_tick ? 16'h0 : (ms_tick ? smp_ms_reg + 16'h1 : smp_ms_reg);
      a_cnt_next  = smp_tick ? 16'h0 : a_cnt_reg + 16'({15'h0, a_rise & ~&a_cnt_reg});
      b_cnt_next  = smp_tick ? 16'h0 : b_cnt_reg + 16'({15'h0, b_rise & ~&b_cnt_reg});
      cur_f_next  = smp_tick ? 32'(a_cnt_reg) * FREQ_SCALE : cur_f_reg; // R13
      prev_f_next = smp_tick ? cur_f_reg : prev_f_reg; // R13
      b_bad_next  = smp_tick ? (a_cnt_reg >= 16'h0002 && b_cnt_reg == 16'h0000) : b_bad_reg;
      b_ok_next   = smp_tick ? (b_cnt_reg != 16'h0000) : b_ok_reg;
      zero_next   = smp_tick ? (a_cnt_reg == 16'h0000) : zero_reg;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt_reg <= 32'h0;
         smp_ms_reg <= 16'h0;
         a_cnt_reg  <= 16'h0;
         b_cnt_reg  <= 16'h0;
         cur_f_reg  <= 32'h0;
         prev_f_reg <= 32'h0;
         b_bad_reg  <= 1'b0;
         b_ok_reg   <= 1'b0;
         zero_reg   <= 1'b1;
      end else begin
         ms_cnt_reg <= ms_cnt_next;
         smp_ms_reg <= smp_ms_next;
         a_cnt_reg  <= a_cnt_next;
         b_cnt_reg  <= b_cnt_next;
         cur_f_reg  <= cur_f_next;
         prev_f_reg <= prev_f_next;
         b_bad_reg  <= b_bad_next;
         b_ok_reg   <= b_ok_next;
         zero_reg   <= zero_next;
      end
   end

   // Loss detection and reaction sequence
   always_comb begin
      thr32   = {16'h0, cfg_reg.threshold};
      // Actual frequency smooths the last two samples; the latest stands alone
      f_act   = 32'(({1'b0, cur_f_reg} + {1'b0, prev_f_reg}) >> 1);
      f_diff  = (cur_f_reg > prev_f_reg) ? cur_f_reg - prev_f_reg : prev_f_reg - cur_f_reg;
      hf_cond = (thr32 != 32'h0) && (f_act > thr32) && (f_diff > thr32); // R04 R05 R11
      hf_ms_next = !hf_cond ? 16'h0 :
                   ((ms_tick && hf_ms_reg < 16'(HF_DELAY_MS)) ? hf_ms_reg + 16'h1 : hf_ms_reg);
      hf_loss = (hf_ms_reg >= 16'(HF_DELAY_MS)); // R06
      zs_ms_next = !(zero_reg && setpoint_positive) ? 16'h0 :
                   ((ms_tick && ~&zs_ms_reg) ? zs_ms_reg + 16'h1 : zs_ms_reg);
      lf_case1 = (f_act < thr32) && zero_reg && torque_at_limit
                 && (zs_ms_reg > cfg_reg.delay_ms); // R08
      lf_case2 = (f_act < thr32) && (cur_f_reg < thr32) && b_bad_reg; // R09
      lf_loss  = (cfg_reg.threshold != 16'h0) && (cfg_reg.delay_ms != 16'h0)
                 && (lf_case1 || lf_case2); // R07 R11 R12
      loss = hf_loss | lf_loss;
      state_next   = state_reg;
      wait_ms_next = wait_ms_reg;
      react_next   = react_reg;
      case (state_reg)
         MON_IDLE: begin
            wait_ms_next = 16'h0;
            if (loss) begin
               state_next = MON_WAIT;
            end
         end
         MON_WAIT: begin
            if (!loss) begin
               state_next = MON_IDLE;
            end else if (wait_ms_reg >= cfg_reg.delay_ms) begin // R10
               state_next = MON_REACT;
               react_next.encoder_loss_fault         = ~cfg_reg.reaction_sel; // R03
               react_next.coast_trip_stop            = ~cfg_reg.reaction_sel;
               react_next.encoder_loss_warning       = cfg_reg.reaction_sel;
               react_next.sensorless_vector_fallback = cfg_reg.reaction_sel;
            end else if (ms_tick) begin
               wait_ms_next = wait_ms_reg + 16'h1;
            end
         end
         MON_REACT: begin
            // Held until software acknowledges; a trip must not self-clear
            if (ack_wr) begin
               state_next = MON_IDLE;
               react_next = '0;
            end
         end
         default: begin
            state_next = MON_IDLE;
            react_next = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hf_ms_reg     <= 16'h0;
         zs_ms_reg     <= 16'h0;
         wait_ms_reg   <= 16'h0;
         state_reg     <= MON_IDLE;
         react_reg     <= '0;
         hf_loss_d_reg <= 1'b0;
         lf_loss_d_reg <= 1'b0;
      end else begin
         hf_ms_reg     <= hf_ms_next;
         zs_ms_reg     <= zs_ms_next;
         wait_ms_reg   <= wait_ms_next;
         state_reg     <= state_next;
         react_reg     <= react_next;
         hf_loss_d_reg <= hf_loss;
         lf_loss_d_reg <= lf_loss;
      end
   end

   assign encoder_loss_fault         = react_reg.encoder_loss_fault;
   assign coast_trip_stop            = react_reg.coast_trip_stop;
   assign encoder_loss_warning       = react_reg.encoder_loss_warning;
   assign sensorless_vector_fallback = react_reg.sensorless_vector_fallback;

   // AHB-Lite slave, zero wait states; reads are captured in the address phase
   function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
      case (ofs)
         CTRL_OFS:     rd_mux = {31'h0, cfg_reg.reaction_sel};
         THRESH_OFS:   rd_mux = {16'h0, cfg_reg.threshold};
         DELAY_OFS:    rd_mux = {16'h0, cfg_reg.delay_ms};
         FREQ_OFS:     rd_mux = f_act;
         LIVE_OFS:     rd_mux = {24'h0, b_ok_reg, z_seen_reg, dir_reg, zero_reg,
                                 hf_loss, lf_loss, state_reg};
         INT_STAT_OFS: rd_mux = {29'h0, stat_reg};
         INT_MASK_OFS: rd_mux = {29'h0, mask_reg};
         default:      rd_mux = 32'h0;
      endcase
   endfunction

   always_comb begin
      acc          = hsel && htrans[1] && hready;
      wr_pend_next = acc && hwrite;
      wr_ofs_next  = acc ? {haddr[7:2], 2'b00} : wr_ofs_reg;
      hrdata_next  = (acc && !hwrite) ? rd_mux({haddr[7:2], 2'b00}) : hrdata;
      ack_wr       = wr_pend_reg && (wr_ofs_reg == CTRL_OFS) && hwdata[1];
      cfg_next     = cfg_reg;
      mask_next    = mask_reg;
      if (wr_pend_reg && wr_ofs_reg == CTRL_OFS) begin
         cfg_next.reaction_sel = hwdata[0];
      end
      if (wr_pend_reg && wr_ofs_reg == THRESH_OFS) begin
         cfg_next.threshold = hwdata[15:0];
      end
      if (wr_pend_reg && wr_ofs_reg == DELAY_OFS) begin
         cfg_next.delay_ms = hwdata[15:0];
      end
      if (wr_pend_reg && wr_ofs_reg == INT_MASK_OFS) begin
         mask_next = hwdata[INT_W-1:0];
      end
      ev = '0;
      ev[INT_HF]    = hf_loss & ~hf_loss_d_reg;
      ev[INT_LF]    = lf_loss & ~lf_loss_d_reg;
      ev[INT_REACT] = (state_next == MON_REACT) && (state_reg != MON_REACT);
      stat_next = stat_reg;
      if (wr_pend_reg && wr_ofs_reg == INT_STAT_OFS) begin
         stat_next = stat_reg & ~hwdata[INT_W-1:0];
      end
      // New events win over a clear in the same cycle
      stat_next = stat_next | ev;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg  <= 8'h00;
         hrdata      <= 32'h0;
         cfg_reg     <= '{reaction_sel: SEL_RST, threshold: THRESH_RST, delay_ms: DELAY_RST};
         stat_reg    <= '0;
         mask_reg    <= '0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_ofs_reg  <= wr_ofs_next;
         hrdata      <= hrdata_next;
         cfg_reg     <= cfg_next;
         stat_reg    <= stat_next;
         mask_reg    <= mask_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(stat_reg & mask_reg);

   a_hf_persist: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
      $rose(hf_loss) |-> $past(hf_cond) && hf_ms_reg == 16'(HF_DELAY_MS))
      else $error("high loss without 40 ms persistence");
   a_hf_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
      !hf_cond |=> hf_ms_reg == 16'h0 && !hf_loss)
      else $error("high loss timer kept without condition");
   a_thr_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
      cfg_reg.threshold == 16'h0 |-> !hf_cond && !lf_loss)
      else $error("monitoring active with zero threshold");
   a_delay_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
      cfg_reg.delay_ms == 16'h0 |-> !lf_loss)
      else $error("low loss active with zero delay");
   a_react_wait: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
      $rose(state_reg == MON_REACT) |-> $past(wait_ms_reg) >= cfg_reg.delay_ms)
      else $error("reaction before loss delay");
   a_coast_sel: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
      $rose(coast_trip_stop) |-> $past(cfg_reg.reaction_sel) == 1'b0 && encoder_loss_fault
      && !sensorless_vector_fallback)
      else $error("trip reaction with wrong select");
   a_sensorless_vector_fallback_sel: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
      $rose(sensorless_vector_fallback) |-> $past(cfg_reg.reaction_sel) && encoder_loss_warning)
      else $error("fallback reaction with wrong select");
   a_case1_time: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
      lf_case1 |-> zero_reg && torque_at_limit && zs_ms_reg > cfg_reg.delay_ms)
      else $error("case one without long zero speed");
   a_case2_trk: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
      lf_case2 |-> b_bad_reg && cur_f_reg < thr32)
      else $error("case two without track fault");
   a_sample_prev: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
      smp_tick |=> prev_f_reg == $past(cur_f_reg) && cur_f_reg == 32'($past(a_cnt_reg))
      * FREQ_SCALE)
      else $error("sample not shifted to previous");
   a_dir_sense: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
      (a_rise && !b_ok_reg) |=> dir_reg == $past(dir_reg))
      else $error("direction changed without track B");
endmodule // speed_encoder_loss_monitor

//--- tb/enc_model.sv
/*
 Behavioural single-ended quadrature encoder with tracks A, B and Z.
 Assumes the bench changes run, b_stuck and quarter right after a ref_clk edge.
*/
`timescale 1ns/100ps
module enc_model (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic       b_stuck,
   input  wire logic [7:0] quarter,
   output logic            trk_a,
   output logic            trk_b,
   output logic            trk_z
);
   logic [1:0] phase = 2'b00;
   logic [7:0] cnt   = 8'h00;
   logic [3:0] turns = 4'h0;

   // One quarter of a track period per quarter cycles while turning
   always @(posedge ref_clk) begin
      if (run) begin
         if (cnt + 8'h01 >= quarter) begin
            cnt   <= 8'h00;
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
               turns <= turns + 4'h1;
            end
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   // Gray sequence, B leads A; a stopped shaft keeps its levels
   assign trk_a = phase[1];
   assign trk_b = b_stuck ? 1'b0 : phase[1] ^ phase[0];
   assign trk_z = (turns == 4'h0) && (phase == 2'h3);
endmodule // enc_model

//--- tb/speed_encoder_loss_monitor_test.sv
/*
 Self-checking bench for the encoder loss monitor, registers over AHB-Lite.
 Assumes CYC_MS shortened to 20 cycles, so one sampling period is 200 cycles.
*/
`timescale 1ns/100ps
module speed_encoder_loss_monitor_test;
   import enc_loss_pkg::*;
   localparam int unsigned CYC = 20;
   localparam int unsigned PER = CYC * 10;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        enc_a, enc_b, enc_z, hready, hreadyout, hresp, irq;
   logic        torque_at_limit = 1'b0;
   logic        setpoint_positive = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] hrdata;
   logic        fault, coast, warn, fallback;
   logic        run = 1'b0;
   logic        b_stuck = 1'b0;
   logic [7:0]  quarter = 8'h05;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          tcyc = 0;

   assign hready = hreadyout;
   enc_model partner (.ref_clk(ref_clk), .run(run), .b_stuck(b_stuck), .quarter(quarter),
                      .trk_a(enc_a), .trk_b(enc_b), .trk_z(enc_z));
   speed_encoder_loss_monitor #(.CYC_MS(CYC)) DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
      .torque_at_limit(torque_at_limit), .setpoint_positive(setpoint_positive),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .encoder_loss_fault(fault), .coast_trip_stop(coast),
      .encoder_loss_warning(warn), .sensorless_vector_fallback(fallback), .irq(irq));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task test_done;
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 10k cycles the scenarios need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      tcyc <= reset_n ? tcyc + 1 : 0;
      if (cyc == 30000) begin
         err_count++;
         test_done;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk({31'h0, hresp}, 32'h0, "bus response");
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, exp, what);
   endtask

   task cfg(input logic sel, input logic [15:0] thr, input logic [15:0] dly);
      wr(CTRL_OFS, {31'h0, sel});
      wr(THRESH_OFS, {16'h0, thr});
      wr(DELAY_OFS, {16'h0, dly});
   endtask

   task outs_chk(input logic [3:0] exp, input string what);
      chk({28'h0, fault, coast, warn, fallback}, {28'h0, exp}, what);
   endtask

   // Acknowledge keeps the select bit; outputs fall after the data phase
   task ack(input logic sel);
      wr(CTRL_OFS, {30'h0, 1'b1, sel});
      repeat (3) @(posedge ref_clk);
      outs_chk(4'h0, "outputs after acknowledge");
   endtask

   task wait_react(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         if (fault === 1'b1 || warn === 1'b1) begin
            break;
         end
      end
      @(posedge ref_clk);
   endtask

   task t_reset;
      rd_chk(CTRL_OFS, 32'h00000000, "control reset");
      rd_chk(THRESH_OFS, 32'h000003E8, "threshold reset");
      rd_chk(DELAY_OFS, 32'h0000000A, "delay reset");
      rd_chk(INT_STAT_OFS, 32'h00000000, "status reset");
      rd_chk(8'h1C, 32'h00000000, "unmapped read");
      outs_chk(4'h0, "outputs after reset");
   endtask

   task t_freq;
      quarter <= 8'h05;
      run     <= 1'b1;
      repeat (3 * PER) @(posedge ref_clk);
      rd_chk(FREQ_OFS, 32'h000186A0, "actual frequency");
      // Track B seen, index seen, shaft turning, idle
      rd_chk(LIVE_OFS, 32'h000000C0, "live status");
      run <= 1'b0;
      repeat (3 * PER) @(posedge ref_clk);
      outs_chk(4'h0, "no loss on clean start and stop");
   endtask

   task t_case1;
      cfg(1'b0, 16'h03E8, 16'h000A);
      wr(INT_MASK_OFS, 32'h00000004);
      torque_at_limit   <= 1'b1;
      setpoint_positive <= 1'b1;
      // Zero speed must outlast the delay, then the reaction waits it again
      repeat (18 * CYC) @(posedge ref_clk);
      outs_chk(4'h0, "reaction too early");
      wait_react(40 * CYC);
      outs_chk(4'b1100, "trip reaction");
      torque_at_limit   <= 1'b0;
      setpoint_positive <= 1'b0;
      rd_chk(INT_STAT_OFS, 32'h00000006, "low loss status");
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      wr(INT_MASK_OFS, 32'h00000000);
      // Mask lands on the edge that ends the data phase
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(INT_STAT_OFS, 32'h00000007);
      wr(INT_MASK_OFS, 32'h00000004);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      ack(1'b0);
   endtask

   task t_case2;
      cfg(1'b1, 16'hFFFF, 16'h000A);
      quarter <= 8'h0A;
      b_stuck <= 1'b1;
      run     <= 1'b1;
      wait_react(80 * CYC);
      outs_chk(4'b0011, "warn and sensorless");
      run <= 1'b0;
      repeat (2 * PER) @(posedge ref_clk);
      b_stuck <= 1'b0;
      ack(1'b1);
   endtask

   task t_off(input logic [15:0] thr, input logic [15:0] dly);
      cfg(1'b0, thr, dly);
      torque_at_limit   <= 1'b1;
      setpoint_positive <= 1'b1;
      repeat (60 * CYC) @(posedge ref_clk);
      outs_chk(4'h0, "monitor disabled");
      torque_at_limit   <= 1'b0;
      setpoint_positive <= 1'b0;
   endtask

   // Shaft spins and stops in turns of one sampling period each
   task t_hf(input logic [15:0] thr, input logic [3:0] exp);
      cfg(1'b0, thr, 16'h0000);
      quarter <= 8'h02;
      while (tcyc % PER != 0) @(posedge ref_clk);
      for (int i = 0; i < 70; i++) begin
         run <= ((i / 10) % 2) == 0;
         repeat (CYC) @(posedge ref_clk);
         if (i == 45) begin
            outs_chk(4'h0, "high loss before persistence");
         end
      end
      outs_chk(exp, "high loss reaction");
      run <= 1'b0;
      // Let both samples settle to zero, else the reaction refires after ack
      repeat (3 * PER) @(posedge ref_clk);
      ack(1'b0);
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset;
      t_freq;
      t_case1;
      t_case2;
      t_off(16'h0000, 16'h000A);
      t_off(16'h03E8, 16'h0000);
      t_hf(16'h0000, 4'h0);
      t_hf(16'h0064, 4'b1100);
      test_done;
   end
endmodule // speed_encoder_loss_monitor_test
